//--- ivp_pkg.sv
// Purpose: Shared constants for the interrupt vector placement control.
// Assumes: Word-addressed program flash, 8-bit control register.
// Notes: Boot start per size code is a table of named constants.
package ivp_pkg;
  // Control register bit positions
  localparam int unsigned CTL_EXT1_BIT = 7;
  localparam int unsigned CTL_EXT0_BIT = 6;
  localparam int unsigned CTL_EXT2_BIT = 5;
  localparam int unsigned CTL_SEL_BIT = 1;
  localparam int unsigned CTL_UNLOCK_BIT = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hE3;
  // Unlock window length in cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Boot section word start address per boot size code
  localparam logic [12:0] BOOT_START_2K = 13'h1C00;
  localparam logic [12:0] BOOT_START_1K = 13'h1E00;
  localparam logic [12:0] BOOT_START_512 = 13'h1F00;
  localparam logic [12:0] BOOT_START_256 = 13'h1F80;
  localparam logic [1:0] BOOT_SIZE_2K = 2'h0;
  localparam logic [1:0] BOOT_SIZE_1K = 2'h1;
  localparam logic [1:0] BOOT_SIZE_512 = 2'h2;
  localparam logic [12:0] FLASH_START = 13'h0000;
  // Unlock sequence states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OPEN = 3'b010,
    ST_HOLD = 3'b100
  } ivp_state_t;
endpackage

//--- ivp_boot_map.sv
// Purpose: Boot section start address from the boot size fuses.
// Assumes: Fuse inputs are static after reset.
// Notes: Purely combinational lookup.
`timescale 1ns/1ps
module ivp_boot_map
  import ivp_pkg::*;
(
  // Fuse setting
  input wire logic [1:0] boot_size_fuses,
  // Boot section start
  output logic [12:0] boot_start
);
  // Size code to start word address
  always_comb begin
    case (boot_size_fuses)
      BOOT_SIZE_2K: boot_start = BOOT_START_2K;
      BOOT_SIZE_1K: boot_start = BOOT_START_1K;
      BOOT_SIZE_512: boot_start = BOOT_START_512;
      default: boot_start = BOOT_START_256;
    endcase
  end
endmodule // ivp_boot_map

//--- ivp_ctrl.sv
// Overview of operation
// - Base select zero puts vectors at flash start, one at boot start.
// - Relocated base comes from the boot size fuse setting.
// - Interrupt masking starts in the cycle unlock becomes set.
// - After select written, mask holds until the next instruction completes.
// - Without a select write, mask lasts four cycles then releases.
// - Automatic masking never touches the global interrupt enable flag.
// - Unlock clears four cycles after written, or when select is written.
// - Vectors in boot and app lock set: mask while running in app.
// - Vectors in app and boot lock set: mask while running in boot.
// - Register bits 7,6,5 ext enables, 1 select, 0 unlock; 4..2 read zero.
// - 2K boot section starts at 0x1C00; vectors 0x1C02 to 0x1C28.
// - Boot reset fuse programmed starts at boot address, else zero.
// - With select set, vector address is table offset plus boot start.
//
// Purpose: Vector table placement control with timed unlock and masking.
// Assumes: Core writes the register as a one-cycle strobe on clk; fuses,
//   lock bits and execution region are static or synchronous to clk.
// Notes: Fuse and lock inputs are active high meaning programmed.
`timescale 1ns/1ps
module ivp_ctrl
  import ivp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control register access from the core
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Core instruction progress, high when an instruction completes
  input wire logic instr_done,
  // Fuses and lock bits, high means programmed
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic app_section_boot_lock,
  input wire logic boot_section_boot_lock,
  // Execution region, high while fetching from the boot section
  input wire logic exec_in_boot,
  // Vector index from the interrupt unit, 0 is reset
  input wire logic [4:0] vector_index,
  // Results to the core
  output logic irq_mask,
  output logic [12:0] vector_addr,
  output logic [12:0] reset_addr,
  output logic ext_irq0_enable,
  output logic ext_irq1_enable,
  output logic ext_irq2_enable,
  output logic vector_base_select
);
  logic [12:0] boot_start;
  logic [7:0] ctl_q, ctl_d;
  logic [2:0] cnt_q, cnt_d;
  ivp_state_t st_q, st_d;
  logic mask_q, mask_d;
  logic [12:0] vaddr_q, vaddr_d, raddr_q, raddr_d;
  logic unlock_wr, sel_wr, lock_mask;

  // Fuse driven boot start lookup
  ivp_boot_map u_map (
    .boot_size_fuses(boot_size_fuses),
    .boot_start(boot_start)
  );

  assign unlock_wr = reg_wr && reg_wdata[CTL_UNLOCK_BIT];
  assign sel_wr = reg_wr && !reg_wdata[CTL_UNLOCK_BIT] && (st_q == ST_OPEN);

  // Lock based masking by execution region
  always_comb begin
    lock_mask = 1'b0;
    if (ctl_d[CTL_SEL_BIT] && app_section_boot_lock && !exec_in_boot)
      lock_mask = 1'b1;
    if (!ctl_d[CTL_SEL_BIT] && boot_section_boot_lock && exec_in_boot)
      lock_mask = 1'b1;
  end

  // Register, unlock sequence and mask next state
  always_comb begin
    ctl_d = ctl_q;
    cnt_d = cnt_q;
    st_d = st_q;
    if (reg_wr) begin
      // Enables always writable; reserved bits stay zero
      ctl_d[CTL_EXT1_BIT] = reg_wdata[CTL_EXT1_BIT];
      ctl_d[CTL_EXT0_BIT] = reg_wdata[CTL_EXT0_BIT];
      ctl_d[CTL_EXT2_BIT] = reg_wdata[CTL_EXT2_BIT];
    end
    case (st_q)
      ST_IDLE: begin
        if (unlock_wr) begin
          st_d = ST_OPEN;
          cnt_d = UNLOCK_CYCLES - 3'h1;
          ctl_d[CTL_UNLOCK_BIT] = 1'b1;
        end
        // Select write without unlock leaves base unchanged
      end
      ST_OPEN: begin
        if (sel_wr) begin
          // Select taken, unlock dropped at once
          ctl_d[CTL_SEL_BIT] = reg_wdata[CTL_SEL_BIT];
          ctl_d[CTL_UNLOCK_BIT] = 1'b0;
          st_d = ST_HOLD;
        end else if (cnt_q == 3'h0) begin
          ctl_d[CTL_UNLOCK_BIT] = 1'b0;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      ST_HOLD: begin
        // Mask until the following instruction completes
        // A fresh unlock here reopens the window; the mask never gaps
        if (unlock_wr) begin
          st_d = ST_OPEN;
          cnt_d = UNLOCK_CYCLES - 3'h1;
          ctl_d[CTL_UNLOCK_BIT] = 1'b1;
        end else if (instr_done) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    ctl_d = ctl_d & CTL_WRITE_MASK;
    // Masking is a separate gate; global enable flag is never touched
    mask_d = (st_d != ST_IDLE) || lock_mask;
  end

  // Vector and reset address computation
  always_comb begin
    vaddr_d = {7'h00, vector_index, 1'b0};
    if (ctl_d[CTL_SEL_BIT])
      vaddr_d = boot_start + {7'h00, vector_index, 1'b0};
    raddr_d = boot_reset_fuse ? boot_start : FLASH_START;
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= CTL_RESET;
      cnt_q <= 3'h0;
      st_q <= ST_IDLE;
      mask_q <= 1'b0;
      vaddr_q <= FLASH_START;
      raddr_q <= FLASH_START;
    end else begin
      ctl_q <= ctl_d;
      cnt_q <= cnt_d;
      st_q <= st_d;
      mask_q <= mask_d;
      vaddr_q <= vaddr_d;
      raddr_q <= raddr_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = ctl_q;
  assign irq_mask = mask_q;
  assign vector_addr = vaddr_q;
  assign reset_addr = raddr_q;
  assign ext_irq0_enable = ctl_q[CTL_EXT0_BIT];
  assign ext_irq1_enable = ctl_q[CTL_EXT1_BIT];
  assign ext_irq2_enable = ctl_q[CTL_EXT2_BIT];
  assign vector_base_select = ctl_q[CTL_SEL_BIT];

  // Checks
  mask_on_unlock_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_IDLE && unlock_wr) |=> irq_mask)
    else $error("mask not raised with unlock");
  unlock_expire_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_IDLE && unlock_wr) ##1 (!reg_wr)[*4]
      |=> !reg_rdata[CTL_UNLOCK_BIT])
    else $error("unlock not cleared after four cycles");
  unlock_held_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_IDLE && unlock_wr) ##1 (!reg_wr)[*3]
      |-> reg_rdata[CTL_UNLOCK_BIT])
    else $error("unlock cleared early");
  mask_release_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_IDLE && unlock_wr && !lock_mask) ##1 (!reg_wr && !lock_mask)[*5]
      |-> !irq_mask)
    else $error("mask not released");
  sel_no_unlock_a: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && st_q == ST_IDLE) |=> $stable(vector_base_select))
    else $error("select changed without unlock");
  sel_taken_a: assert property (@(posedge clk) disable iff (!resetn)
    sel_wr |=> (vector_base_select == $past(reg_wdata[CTL_SEL_BIT]))
      && !reg_rdata[CTL_UNLOCK_BIT])
    else $error("select write lost");
  hold_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_HOLD && !instr_done) |-> ##1 irq_mask)
    else $error("mask dropped before instruction done");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    reg_rdata[4:2] == 3'h0)
    else $error("reserved bits nonzero");
  vec_boot_a: assert property (@(posedge clk) disable iff (!resetn)
    (ctl_d[CTL_SEL_BIT] && boot_size_fuses == BOOT_SIZE_2K
      && vector_index == 5'h01) |=> vector_addr == 13'h1C02)
    else $error("relocated vector address wrong");
  lock_app_a: assert property (@(posedge clk) disable iff (!resetn)
    (ctl_d[CTL_SEL_BIT] && app_section_boot_lock && !exec_in_boot)
      |=> irq_mask)
    else $error("app region not masked");
  lock_boot_a: assert property (@(posedge clk) disable iff (!resetn)
    (!ctl_d[CTL_SEL_BIT] && boot_section_boot_lock && exec_in_boot)
      |=> irq_mask)
    else $error("boot region not masked");
  unlock_rearm_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_HOLD && unlock_wr)
      |=> (reg_rdata[CTL_UNLOCK_BIT] && irq_mask))
    else $error("unlock refused after select write");
  mask_free_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == ST_HOLD && instr_done && !reg_wr && !lock_mask)
      |=> !irq_mask)
    else $error("mask held after instruction done");
  vec_flash_a: assert property (@(posedge clk) disable iff (!resetn)
    !ctl_d[CTL_SEL_BIT]
      |=> vector_addr == {7'h00, $past(vector_index), 1'b0})
    else $error("flash vector address wrong");
  vec_last_a: assert property (@(posedge clk) disable iff (!resetn)
    (ctl_d[CTL_SEL_BIT] && boot_size_fuses == BOOT_SIZE_2K
      && vector_index == 5'h14) |=> vector_addr == 13'h1C28)
    else $error("last relocated vector address wrong");
  reset_flash_a: assert property (@(posedge clk) disable iff (!resetn)
    !boot_reset_fuse |=> reset_addr == FLASH_START)
    else $error("reset address not at flash start");
endmodule // ivp_ctrl

//--- ivp_core_model.sv
// Purpose: Core model driving control register writes.
// Assumes: Bench issues at most one write per cycle.
// Notes: Idle data flips every cycle so a stray sample shows.
`timescale 1ns/1ps
module ivp_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Requests from the bench
  input wire logic op_wr,
  input wire logic [7:0] op_data,
  // Core side of the block
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  logic [7:0] last_q;
  // One-cycle strobe per write; unlock and select order set by the bench
  assign reg_wr = op_wr;
  assign reg_wdata = op_wr ? op_data : ~last_q;
  // Remember the bus so an idle cycle never repeats it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_q <= 8'h00;
    end else begin
      last_q <= reg_wdata;
    end
  end
endmodule // ivp_core_model

//--- tb_top.sv
// Purpose: Self-checking bench for the vector placement control.
// Assumes: One step per clock; its result shows after the next edge.
// Notes: A queue pairs each step with the outputs it should produce.
`timescale 1ns/1ps
module tb_top;
  import ivp_pkg::*;
  typedef struct {
    logic [7:0] rd;
    logic m;
    logic ca;
    logic [12:0] va;
    logic [12:0] ra;
  } ivp_note_t;
  logic clk = 1'b0, resetn = 1'b0, op_wr = 1'b0, instr_done = 1'b0;
  logic brf = 1'b0, al = 1'b0, bl = 1'b0, xb = 1'b0, stp = 1'b0, pv = 1'b0;
  logic reg_wr, irq_mask, x0, x1, x2, vsel;
  logic [7:0] op_data = 8'h00, en = 8'h00, reg_wdata, reg_rdata;
  logic [1:0] bsz = 2'h0;
  logic [4:0] vidx = 5'h00;
  logic [12:0] vector_addr, reset_addr;
  ivp_note_t q[$];
  int bad_count = 0, n_tests = 0;
  ivp_ctrl dut_u (.clk, .resetn, .reg_wr, .reg_wdata, .reg_rdata,
    .instr_done, .boot_reset_fuse(brf), .boot_size_fuses(bsz),
    .app_section_boot_lock(al), .boot_section_boot_lock(bl),
    .exec_in_boot(xb), .vector_index(vidx), .irq_mask, .vector_addr,
    .reset_addr, .ext_irq0_enable(x0), .ext_irq1_enable(x1),
    .ext_irq2_enable(x2), .vector_base_select(vsel));
  ivp_core_model core_u (.clk, .resetn, .op_wr, .op_data, .reg_wr,
    .reg_wdata);
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp_reg(ivp_note_t n);
    n_tests++;
    if (reg_rdata !== n.rd || irq_mask !== n.m ||
        {x1, x0, x2, vsel} !== {n.rd[7:5], n.rd[1]}) begin
      bad_count++;
      $display("ERROR %0t reg %h mask %b", $time, reg_rdata, irq_mask);
    end
  endtask
  task automatic cmp_addr(ivp_note_t n);
    n_tests++;
    if (vector_addr !== n.va || reset_addr !== n.ra) begin
      bad_count++;
      $display("ERROR %0t addr %h %h", $time, vector_addr, reset_addr);
    end
  endtask
  // Drive one cycle and note what it should give
  task automatic step(logic w, logic [7:0] d, logic dn, logic [7:0] rd,
      logic m, logic ca = 1'b0, logic [12:0] va = 13'h0000,
      logic [12:0] ra = 13'h0000);
    q.push_back('{rd, m, ca, va, ra});
    op_wr <= w;
    op_data <= d;
    instr_done <= dn;
    stp <= 1'b1;
    @(posedge clk);
  endtask
  // Oldest note is judged once its edge has landed
  always @(posedge clk) begin
    pv <= stp;
    #1;
    if (pv && q.size() > 0) begin
      cmp_reg(q[0]);
      if (q[0].ca) begin
        cmp_addr(q[0]);
      end
      void'(q.pop_front());
    end
  end
  // Watchdog, far beyond the sixty or so cycles needed
  initial begin
    #50us;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    logic [12:0] bs [4];
    logic [4:0] v;
    logic [7:0] d;
    bs = '{BOOT_START_2K, BOOT_START_1K, BOOT_START_512, BOOT_START_256};
    void'($urandom(32'h36e2));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Closed window: enables land, select and bits 4..2 stay zero
    d = 8'($urandom()) | 8'h1E;
    en = d & 8'hE0;
    step(1'b1, d & 8'hFE, 1'b0, en, 1'b0);
    // Unlock left to expire: four masked cycles then clear
    step(1'b1, en | 8'h01, 1'b0, en | 8'h01, 1'b1);
    repeat (3) step(1'b0, 8'h00, 1'b0, en | 8'h01, 1'b1);
    step(1'b0, 8'h00, 1'b0, en, 1'b0);
    // Move table to boot; mask waits for the next completed instruction
    step(1'b1, en | 8'h01, 1'b0, en | 8'h01, 1'b1);
    step(1'b1, en | 8'h02, 1'b1, en | 8'h02, 1'b1);
    step(1'b0, 8'h00, 1'b0, en | 8'h02, 1'b1);
    step(1'b0, 8'h00, 1'b1, en | 8'h02, 1'b0);
    // Relocated table at every boot size, reset fuse both ways
    for (int s = 0; s < 4; s++) begin
      bsz <= 2'(s);
      brf <= s[0];
      for (int k = 0; k < 3; k++) begin
        v = (k == 0) ? 5'h01 : (k == 1) ? 5'h14 : 5'(1 + $urandom_range(19));
        vidx <= v;
        step(1'b0, 8'h00, 1'b0, en | 8'h02, 1'b0, 1'b1,
          bs[s] + {7'h00, v, 1'b0}, s[0] ? bs[s] : FLASH_START);
      end
    end
    // App lock masks only while running outside the boot section
    al <= 1'b1;
    step(1'b0, 8'h00, 1'b0, en | 8'h02, 1'b1);
    xb <= 1'b1;
    step(1'b0, 8'h00, 1'b0, en | 8'h02, 1'b0);
    al <= 1'b0;
    // Table back to flash start
    step(1'b1, en | 8'h01, 1'b0, en | 8'h03, 1'b1);
    step(1'b1, en, 1'b1, en, 1'b1);
    step(1'b0, 8'h00, 1'b1, en, 1'b0);
    // Boot lock masks only while running in the boot section
    bl <= 1'b1;
    step(1'b0, 8'h00, 1'b0, en, 1'b1);
    xb <= 1'b0;
    v = 5'(1 + $urandom_range(19));
    vidx <= v;
    step(1'b0, 8'h00, 1'b0, en, 1'b0, 1'b1, {7'h00, v, 1'b0}, bs[3]);
    // Unlock again straight after a select write reopens the window
    step(1'b1, en | 8'h01, 1'b0, en | 8'h01, 1'b1);
    step(1'b1, en | 8'h02, 1'b0, en | 8'h02, 1'b1);
    step(1'b1, en | 8'h01, 1'b0, en | 8'h03, 1'b1);
    step(1'b1, en, 1'b0, en, 1'b1);
    step(1'b0, 8'h00, 1'b1, en, 1'b0);
    stp <= 1'b0;
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule // tb_top
